// *** include/smic_pkg.sv ***
package smic_pkg;
   // Counter geometry
   localparam int unsigned NUM_GROUPS = 2;
   localparam int unsigned PER_GROUP = 3;
   localparam int unsigned NUM_CTR = 6;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned IDX_W = 3;
   localparam int unsigned MODE_W = 3;
   // Reset and constant values
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_TWO = 16'h0002;
   // On-board clock divider: 20 MHz system clock down to 10 MHz
   localparam int unsigned SYS_CLK_KHZ = 20000;
   localparam int unsigned ONBOARD_CLK_KHZ = 10000;
   localparam int unsigned ONBOARD_DIV = SYS_CLK_KHZ / ONBOARD_CLK_KHZ;
   // Operating modes
   typedef enum logic [2:0] {
      SMIC_MODE_TC = 3'b000,
      SMIC_MODE_ONESHOT = 3'b001,
      SMIC_MODE_RATE = 3'b010,
      SMIC_MODE_SQUARE = 3'b011,
      SMIC_MODE_SWSTROBE = 3'b100,
      SMIC_MODE_HWSTROBE = 3'b101
   } smic_mode_t;
endpackage

// *** include/smic_ctr_if.sv ***
`timescale 1ns/100ps
// Signals between the top and one counter channel
interface smic_ctr_if;
   logic cnt_tick;
   logic gate_lvl;
   logic gate_rise;
   logic load;
   smic_pkg::smic_mode_t mode;
   logic [15:0] value;
   logic [15:0] count;
   logic out;
   modport top (output cnt_tick, gate_lvl, gate_rise, load, mode, value,
      input count, out);
   modport chan (input cnt_tick, gate_lvl, gate_rise, load, mode, value,
      output count, out);
endinterface

// *** verilog/smic_channel.sv ***
`timescale 1ns/100ps
// One 16-bit down-counter with six modes
module smic_channel (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Control and status
   smic_ctr_if.chan ctl
);
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] init;
      smic_pkg::smic_mode_t mode;
      logic out;
      logic armed;
      logic running;
      logic trig;
      logic half;
   } smic_chan_st_t;

   smic_chan_st_t st;
   smic_chan_st_t next_st;

   // ==========================================
   // Next state
   always_comb begin
      next_st = st;
      if (ctl.gate_rise) begin
         next_st.trig = 1'b1; // R4
      end
      if (ctl.load) begin
         next_st.init = ctl.value; // R2
         next_st.mode = ctl.mode;
         next_st.trig = 1'b0;
         next_st.armed = 1'b1;
         next_st.running = 1'b0;
         next_st.half = 1'b0;
         unique case (ctl.mode)
            smic_pkg::SMIC_MODE_TC: next_st.out = 1'b0; // R5
            default: next_st.out = 1'b1;
         endcase
      end else if (ctl.cnt_tick && st.armed) begin
         next_st.trig = 1'b0;
         unique case (st.mode)
            smic_pkg::SMIC_MODE_TC: begin
               if (!st.running) begin
                  next_st.count = st.init;
                  next_st.running = 1'b1;
               end else if (ctl.gate_lvl && !st.out) begin // R6
                  next_st.count = st.count - smic_pkg::CNT_ONE;
                  if (st.count == smic_pkg::CNT_ONE) begin
                     next_st.out = 1'b1; // R5
                  end
               end
            end
            smic_pkg::SMIC_MODE_ONESHOT: begin
               if (st.trig || ctl.gate_rise) begin
                  next_st.count = st.init; // R8
                  next_st.out = 1'b0; // R7
                  next_st.running = 1'b1;
               end else if (st.running) begin
                  next_st.count = st.count - smic_pkg::CNT_ONE;
                  if (st.count == smic_pkg::CNT_ONE) begin
                     next_st.out = 1'b1; // R7
                     next_st.running = 1'b0;
                  end
               end
            end
            smic_pkg::SMIC_MODE_RATE: begin
               if (!ctl.gate_lvl) begin
                  next_st.out = 1'b1; // R10
                  next_st.running = 1'b0;
               end else if (!st.running || st.trig || ctl.gate_rise) begin
                  next_st.count = st.init;
                  next_st.running = 1'b1;
                  next_st.out = 1'b1;
               end else if (st.count == smic_pkg::CNT_TWO) begin
                  next_st.count = smic_pkg::CNT_ONE;
                  next_st.out = 1'b0; // R9
               end else if (st.count == smic_pkg::CNT_ONE) begin
                  next_st.count = st.init; // R9
                  next_st.out = 1'b1;
               end else begin
                  next_st.count = st.count - smic_pkg::CNT_ONE;
               end
            end
            smic_pkg::SMIC_MODE_SQUARE: begin
               if (!ctl.gate_lvl) begin
                  next_st.out = 1'b1;
                  next_st.running = 1'b0;
               end else if (!st.running || st.trig || ctl.gate_rise) begin
                  next_st.count = {st.init[15:1], 1'b0}; // R12
                  next_st.running = 1'b1;
                  next_st.out = 1'b1;
                  next_st.half = st.init[0];
               end else if (st.count == smic_pkg::CNT_TWO ||
                            st.count == smic_pkg::CNT_ONE) begin
                  // Odd count: extra tick held on the high half
                  if (st.half && st.out) begin
                     next_st.count = smic_pkg::CNT_ONE;
                     next_st.half = 1'b0;
                  end else begin
                     next_st.count = {st.init[15:1], 1'b0}; // R12
                     next_st.out = ~st.out; // R11
                     next_st.half = st.init[0] && !st.out;
                  end
               end else begin
                  next_st.count = st.count - smic_pkg::CNT_TWO; // R12
               end
            end
            smic_pkg::SMIC_MODE_SWSTROBE: begin
               if (!st.running) begin
                  next_st.count = st.init; // R13
                  next_st.running = 1'b1;
               end else if (!st.out) begin
                  next_st.out = 1'b1; // R13
                  next_st.armed = 1'b0;
               end else if (ctl.gate_lvl) begin // R14
                  next_st.count = st.count - smic_pkg::CNT_ONE;
                  if (st.count == smic_pkg::CNT_ONE) begin
                     next_st.out = 1'b0; // R13
                  end
               end
            end
            smic_pkg::SMIC_MODE_HWSTROBE: begin
               if (st.trig || ctl.gate_rise) begin
                  next_st.count = st.init; // R15 R16
                  next_st.running = 1'b1;
                  next_st.out = 1'b1;
               end else if (!st.out) begin
                  next_st.out = 1'b1;
               end else if (st.running) begin
                  next_st.count = st.count - smic_pkg::CNT_ONE;
                  if (st.count == smic_pkg::CNT_ONE) begin
                     next_st.out = 1'b0; // R15
                     next_st.running = 1'b0;
                  end
               end
            end
            default: next_st.armed = 1'b0;
         endcase
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{count: smic_pkg::CNT_RESET, init: smic_pkg::CNT_RESET,
            mode: smic_pkg::SMIC_MODE_TC, out: 1'b1, armed: 1'b0,
            running: 1'b0, trig: 1'b0, half: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign ctl.count = st.count; // R18
   assign ctl.out = st.out;
endmodule // smic_channel

// *** verilog/smic_top.sv ***
`timescale 1ns/100ps
// Contract
// (R1) Six independent 16-bit down-counters in two groups of three.
// (R2) Load values 1 or 2 up to 65,536; zero means full range.
// (R3) A 10 MHz on-board clock may serve as counting source.
// (R4) Count on clock pulses; trigger only on gate rising edge.
// (R5) Mode 0: load drives output low; high at zero until reload.
// (R6) Mode 0: decrement only while the gate is high.
// (R7) Mode 1: output low after trigger, high again at zero.
// (R8) Mode 1: trigger before zero reloads and extends the pulse.
// (R9) Mode 2: divide by N, one-period low pulse, then reload.
// (R10) Mode 2: runs while gate high, stops when gate low.
// (R11) Mode 3: square wave, odd N high (N+1)/2, low (N-1)/2.
// (R12) Mode 3: decrement by two each half, reloading between halves.
// (R13) Mode 4: output high at load, low one period at zero.
// (R14) Mode 4: low gate inhibits counting.
// (R15) Mode 5: count after gate rise, one-period low at terminal count.
// (R16) Mode 5: retriggerable; pulse only after full count from last edge.
// (R17) Clock, gate and output of every counter are separate pins.
// (R18) Host loads mode and value per counter and reads current count.
module smic_top (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Counter pins, nine per group of three
   input wire logic [5:0] ctr_clk,
   input wire logic [5:0] ctr_gate,
   output logic [5:0] ctr_out,
   // Source select: high uses on-board clock instead of pin
   input wire logic [5:0] use_onboard,
   // On-board clock pin
   output logic onboard_clk,
   // Host command port
   input wire logic host_load,
   input wire logic [2:0] host_index,
   input wire logic [2:0] host_mode,
   input wire logic [15:0] host_value,
   input wire logic host_read,
   output logic [15:0] host_rdata,
   output logic host_rvalid
);
   typedef struct packed {
      logic [5:0] clk_s1;
      logic [5:0] clk_s2;
      logic [5:0] clk_d;
      logic [5:0] gate_s1;
      logic [5:0] gate_s2;
      logic [5:0] gate_d;
      logic ob_clk;
      logic ob_d;
      logic [5:0] outs;
      logic [15:0] rdata;
      logic rvalid;
   } smic_top_st_t;

   smic_top_st_t st;
   smic_top_st_t next_st;
   logic [15:0] counts [6];
   logic [5:0] ch_out;
   logic [5:0] ch_load;
   smic_pkg::smic_mode_t ch_mode;

   // Mode word decode, illegal codes fall back to mode 0
   function automatic smic_pkg::smic_mode_t smic_dec_mode(
      input logic [2:0] code);
      smic_pkg::smic_mode_t m;
      m = smic_pkg::SMIC_MODE_TC;
      if (code <= 3'h5) begin
         m = smic_pkg::smic_mode_t'(code); // R18
      end
      return m;
   endfunction

   // Index decode used for loads
   function automatic logic [5:0] smic_dec_idx(input logic [2:0] idx,
      input logic en);
      logic [5:0] hot;
      hot = 6'h00;
      if (en && idx <= 3'h5) begin
         hot[idx] = 1'b1;
      end
      return hot;
   endfunction

   assign ch_mode = smic_dec_mode(host_mode);
   assign ch_load = smic_dec_idx(host_index, host_load);

   // ==========================================
   // Per-counter channels
   genvar g;
   generate
      for (g = 0; g < smic_pkg::NUM_CTR; g++) begin : gen_ctr // R1 R17
         smic_ctr_if ifc ();
         // Rising edge of the selected count source, pin source 2-flop synced
         assign ifc.cnt_tick = use_onboard[g]
            ? (st.ob_clk && !st.ob_d) // R3
            : (st.clk_s2[g] && !st.clk_d[g]); // R4
         assign ifc.gate_lvl = st.gate_s2[g];
         assign ifc.gate_rise = st.gate_s2[g] && !st.gate_d[g]; // R4
         assign ifc.load = ch_load[g];
         assign ifc.mode = ch_mode;
         assign ifc.value = host_value; // R2
         assign counts[g] = ifc.count;
         assign ch_out[g] = ifc.out;
         smic_channel u_chan (
            .clock(clock),
            .rst_n(rst_n),
            .ctl(ifc.chan)
         );
      end
   endgenerate

   // ==========================================
   // Synchronisers, on-board clock and read path
   always_comb begin
      next_st = st;
      next_st.clk_s1 = ctr_clk;
      next_st.clk_s2 = st.clk_s1;
      next_st.clk_d = st.clk_s2;
      next_st.gate_s1 = ctr_gate;
      next_st.gate_s2 = st.gate_s1;
      next_st.gate_d = st.gate_s2;
      next_st.ob_clk = ~st.ob_clk; // R3
      next_st.ob_d = st.ob_clk;
      next_st.outs = ch_out; // R17
      next_st.rvalid = 1'b0;
      if (host_read && host_index <= 3'h5) begin
         next_st.rdata = counts[host_index]; // R18
         next_st.rvalid = 1'b1;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{clk_s1: 6'h00, clk_s2: 6'h00, clk_d: 6'h00,
            gate_s1: 6'h00, gate_s2: 6'h00, gate_d: 6'h00,
            ob_clk: 1'b0, ob_d: 1'b0, outs: 6'h3f,
            rdata: smic_pkg::CNT_RESET, rvalid: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign ctr_out = st.outs;
   assign onboard_clk = st.ob_clk;
   assign host_rdata = st.rdata;
   assign host_rvalid = st.rvalid;
endmodule // smic_top

// *** verification/smic_src.sv ***
`timescale 1ns/100ps
// ====
// External clock and gate sources
module smic_src (
   // System
   input wire logic clock,
   // Pins
   output logic [5:0] ctr_clk,
   output logic [5:0] ctr_gate
);
   // Clocks idle low, gates high
   initial begin
      ctr_clk = 6'h00;
      ctr_gate = 6'h3f;
   end
   // One positive pulse, 3 clocks high, 3 low
   task automatic pulse(input int k);
      @(posedge clock) ctr_clk[k] <= 1'b1;
      repeat (3) @(posedge clock);
      ctr_clk[k] <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // Gate level change, then settle
   task automatic gate(input int k, input logic v);
      @(posedge clock) ctr_gate[k] <= v;
      repeat (4) @(posedge clock);
   endtask
endmodule // smic_src

// *** verification/smic_top_chk.sv ***
`timescale 1ns/100ps
// ====
// Port checker
module smic_top_chk (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Pins
   input wire logic [5:0] ctr_clk,
   input wire logic [5:0] ctr_gate,
   input wire logic [5:0] ctr_out,
   input wire logic [5:0] use_onboard,
   input wire logic onboard_clk,
   // Host
   input wire logic host_load,
   input wire logic [2:0] host_index,
   input wire logic [2:0] host_mode,
   input wire logic [15:0] host_value,
   input wire logic host_read,
   input wire logic [15:0] host_rdata,
   input wire logic host_rvalid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // No load and no pin activity
   sequence s_quiet;
      (!host_load && use_onboard == 6'h00 && $stable(ctr_clk)
         && $stable(ctr_gate)) [*8];
   endsequence
   read_answer_a: assert property (
      host_read && host_index <= 3'h5 |=> host_rvalid)
      else $error("read not answered");
   rvalid_cause_a: assert property (
      host_rvalid |-> $past(host_read) && $past(host_index) <= 3'h5)
      else $error("answer without read");
   bad_index_a: assert property (
      host_read && host_index > 3'h5 |=> !host_rvalid)
      else $error("bad index answered");
   rdata_hold_a: assert property (
      !host_rvalid |-> $stable(host_rdata))
      else $error("read data moved");
   onboard_tog_a: assert property (
      $past(rst_n) |-> onboard_clk != $past(onboard_clk))
      else $error("onboard clock stuck");
   quiet_out_a: assert property (
      s_quiet |-> $stable(ctr_out))
      else $error("output moved without cause");
   // Per-counter load effects
   for (genvar k = 0; k < 6; k++) begin : g_ch
      m0_load_a: assert property (
         host_load && host_index == k && host_mode == 3'h0
         |-> ##2 !ctr_out[k])
         else $error("mode 0 load left output high");
      m4_load_a: assert property (
         host_load && host_index == k && host_mode == 3'h4
         |-> ##2 ctr_out[k])
         else $error("mode 4 load left output low");
   end
endmodule // smic_top_chk

bind smic_top smic_top_chk smic_top_chk_inst (.clock(clock), .rst_n(rst_n),
   .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out),
   .use_onboard(use_onboard), .onboard_clk(onboard_clk),
   .host_load(host_load), .host_index(host_index), .host_mode(host_mode),
   .host_value(host_value), .host_read(host_read),
   .host_rdata(host_rdata), .host_rvalid(host_rvalid));

// *** verification/smic_top_tb.sv ***
`timescale 1ns/100ps
// ====
// Bench for the six-counter block
module smic_top_tb;
   logic clock, rst_n, host_load, host_read, onboard_clk, host_rvalid;
   logic [5:0] ctr_clk, ctr_gate, ctr_out, use_onboard;
   logic [2:0] host_index, host_mode;
   logic [15:0] host_value, host_rdata, v;
   int n_fail, cmp_count, seed, n;
   smic_top smic_top_inst (.clock(clock), .rst_n(rst_n),
      .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out),
      .use_onboard(use_onboard), .onboard_clk(onboard_clk),
      .host_load(host_load), .host_index(host_index),
      .host_mode(host_mode), .host_value(host_value),
      .host_read(host_read), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid));
   smic_src smic_src_inst (.clock(clock), .ctr_clk(ctr_clk),
      .ctr_gate(ctr_gate));
   // Clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Verdict
   task automatic end_sim();
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Host load of mode and value
   task automatic load(input int k, input int m, input int val);
      @(posedge clock);
      host_load <= 1'b1;
      host_index <= 3'(k);
      host_mode <= 3'(m);
      host_value <= 16'(val);
      @(posedge clock);
      host_load <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // Host read, answer one cycle later
   task automatic rd(input int k, input logic ev, output logic [15:0] d);
      @(posedge clock);
      host_read <= 1'b1;
      host_index <= 3'(k);
      @(posedge clock);
      host_read <= 1'b0;
      #1 chk(16'(host_rvalid), 16'(ev));
      d = host_rdata;
   endtask
   // One counter clock pulse, then settle
   task automatic tick(input int k);
      smic_src_inst.pulse(k);
      repeat (3) @(posedge clock);
      #1;
   endtask
   // Expected output t ticks after load or trigger
   function automatic logic exp_out(int m, int c, int t);
      case (m)
         0: return t > c;
         1: return !(t >= 1 && t <= c);
         2: return ((t - 1) % c) != c - 1;
         3: return ((t - 1) % c) < (c + 1) / 2;
         default: return t != c + 1;
      endcase
   endfunction
   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_sim();
   end
   // Main sequence
   initial begin
      seed = 32'h8e00538e;
      n_fail = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      host_load = 1'b0;
      host_read = 1'b0;
      host_index = 3'h0;
      host_mode = 3'h0;
      host_value = 16'h0000;
      use_onboard = 6'h00;
      repeat (10) @(posedge clock);
      #1 chk(16'(ctr_out), 16'h003f);
      @(posedge clock) rst_n <= 1'b1;
      // Every mode on its own counter
      for (int m = 0; m < 6; m++) begin
         n = 2 + ($unsigned($random(seed)) % 4);
         if (m == 1 || m == 5) smic_src_inst.gate(m, 1'b0);
         load(m, m, n);
         if (m == 1 || m == 5) smic_src_inst.gate(m, 1'b1);
         for (int t = 1; t <= 2 * n + 2; t++) begin
            tick(m);
            chk(16'(ctr_out[m]), 16'(exp_out(m, n, t)));
            if (m == 0 && t <= n + 1) begin
               rd(0, 1'b1, v);
               chk(v, 16'(n - t + 1));
            end
         end
      end
      // Retrigger in mid-count
      for (int m = 1; m < 6; m += 4) begin
         smic_src_inst.gate(m, 1'b0);
         load(m, m, 4);
         smic_src_inst.gate(m, 1'b1);
         tick(m);
         tick(m);
         smic_src_inst.gate(m, 1'b0);
         smic_src_inst.gate(m, 1'b1);
         for (int t = 1; t <= 5; t++) begin
            tick(m);
            chk(16'(ctr_out[m]), 16'(exp_out(m, 4, t)));
         end
      end
      // Low gate holds the count
      for (int m = 0; m < 5; m += 4) begin
         load(0, m, 3);
         tick(0);
         smic_src_inst.gate(0, 1'b0);
         repeat (3) tick(0);
         rd(0, 1'b1, v);
         chk(v, 16'h0003);
         smic_src_inst.gate(0, 1'b1);
         repeat (3) tick(0);
         chk(16'(ctr_out[0]), 16'(exp_out(m, 3, 4)));
      end
      // Zero load stands for the full range
      load(1, 0, 0);
      tick(1);
      tick(1);
      rd(1, 1'b1, v);
      chk(v, 16'hffff);
      rd(6, 1'b0, v);
      // On-board source, illegal mode code taken as mode 0
      @(posedge clock) use_onboard <= 6'h08;
      load(3, 7, 4);
      #1 chk(16'(ctr_out[3]), 16'h0000);
      repeat (20) @(posedge clock);
      #1 chk(16'(ctr_out[3]), 16'h0001);
      rd(3, 1'b1, v);
      chk(v, 16'h0000);
      // Reset in mid-run sets outputs high and clears counts
      @(posedge clock) rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk(16'(ctr_out), 16'h003f);
      @(posedge clock) rst_n <= 1'b1;
      rd(3, 1'b1, v);
      chk(v, 16'h0000);
      end_sim();
   end
endmodule // smic_top_tb
